/* include/tco_chan_if.sv */
// Signals between the control block and one timer's three-channel unit.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
interface tco_chan_if (
    input logic clk,
    input logic rst_n
);
    logic [2:0][1:0] action;          // Output action per channel, A at index 0
    logic [3:0] mode;                 // Full waveform_mode_select
    logic [15:0] counter_value;       // Timer count
    logic [15:0] top_value;           // Current TOP of the timer
    logic [2:0][15:0] compare_value;  // channel_compare_value per channel
    logic count_up;                   // High while counting up
    logic tick;                       // One-cycle timer clock enable
    logic [2:0] oc;                   // Compare output levels
    logic [2:0] connect;              // Output owns the pin

    modport unit (input clk, input rst_n, input action, input mode, input counter_value,
                  input top_value, input compare_value, input count_up, input tick,
                  output oc, output connect);
    modport ctrl (output action, output mode, output counter_value, output top_value,
                  output compare_value, output count_up, output tick,
                  input oc, input connect);
endinterface : tco_chan_if

/* include/tco_pkg.sv */
// Constants, types and the waveform-mode decoder shared by the compare-output
// control block and its per-timer channel unit.
// Assumes a 16-bit up/down timer core outside that supplies counter state.
package tco_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets on the APB slave
    // ------------------------------------------------------------------
    localparam logic [7:0] TCO_OFS_CTRL_T1 = 8'h00;   // Timer1 output and mode control
    localparam logic [7:0] TCO_OFS_CTRL_T3 = 8'h04;   // Timer3 output and mode control
    localparam logic [7:0] TCO_OFS_SECOND_T1 = 8'h08; // Timer1 second control (mode high)
    localparam logic [7:0] TCO_OFS_SECOND_T3 = 8'h0C; // Timer3 second control (mode high)
    localparam logic [7:0] TCO_OFS_STATUS = 8'h10;    // Output levels and connections

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned TCO_CHAN_A_POS = 6;        // Channel A action, bits 7:6
    localparam int unsigned TCO_CHAN_B_POS = 4;        // Channel B action, bits 5:4
    localparam int unsigned TCO_CHAN_C_POS = 2;        // Channel C action, bits 3:2
    localparam int unsigned TCO_MODE_LOW_POS = 0;      // Mode low bits, bits 1:0
    localparam int unsigned TCO_MODE_HIGH_POS = 3;     // Mode high bits, bits 4:3
    localparam int unsigned TCO_STAT_OC_POS = 0;       // Output levels, bits 5:0
    localparam int unsigned TCO_STAT_CONN_POS = 8;     // Connections, bits 13:8
    localparam logic [7:0] TCO_CTRL_RST = 8'h00;
    localparam logic [1:0] TCO_SECOND_RST = 2'h0;

    // ------------------------------------------------------------------
    // Output-action codes and special mode values
    // ------------------------------------------------------------------
    localparam logic [1:0] TCO_ACT_OFF = 2'h0;
    localparam logic [1:0] TCO_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] TCO_ACT_CLEAR = 2'h2;
    localparam logic [1:0] TCO_ACT_SET = 2'h3;
    localparam logic [3:0] TCO_MODE_FAST_A_TOP = 4'hF;  // Fast PWM, TOP from channel A
    localparam logic [3:0] TCO_MODE_PFC_A_TOP = 4'h9;   // Phase/freq correct, TOP from A
    localparam logic [3:0] TCO_MODE_PC_A_TOP = 4'hB;    // Phase correct, TOP from A
    localparam logic [15:0] TCO_CNT_BOTTOM = 16'h0000;

    // Waveform class, Gray coded along normal -> PC -> CTC -> fast -> PFC -> reserved
    typedef enum logic [2:0] {
        TCO_CLS_NORMAL = 3'h0,
        TCO_CLS_PC = 3'h1,
        TCO_CLS_CTC = 3'h3,
        TCO_CLS_FAST = 3'h2,
        TCO_CLS_PFC = 3'h6,
        TCO_CLS_RSVD = 3'h7
    } tco_mode_class_type;

    // decode of the four-bit waveform mode
    function automatic tco_mode_class_type tco_mode_class(input logic [3:0] m);
        case (m)
            4'h0: tco_mode_class = TCO_CLS_NORMAL;
            4'h1, 4'h2, 4'h3, 4'hA, 4'hB: tco_mode_class = TCO_CLS_PC;
            4'h4, 4'hC: tco_mode_class = TCO_CLS_CTC;
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: tco_mode_class = TCO_CLS_FAST;
            4'h8, 4'h9: tco_mode_class = TCO_CLS_PFC;
            default: tco_mode_class = TCO_CLS_RSVD;
        endcase
    endfunction : tco_mode_class

endpackage : tco_pkg

/* sim/tb_top.sv */
// Self-checking bench for the compare-output control block: APB register access, then timer1 channel A.
// Assumes one-wait-state APB and a one-cycle count_tick per timer step.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, err;
    logic [1:0][15:0] counter_value = '0, top_value = {2{16'h00ff}};
    logic [1:0] count_up = 2'h3, count_tick = 2'h0;
    logic [1:0][2:0][15:0] channel_compare_value = {2{16'h0030, 16'h0020, 16'h0010}};
    logic [1:0][2:0] port_data = {2{3'h1}}, port_dir = {2{3'h7}}, pin_out, pin_oe_n, pin_level;
    int num_errors = 0, num_checks = 0;
    always #4 pclk = ~pclk;  // 125 MHz
    tco_output_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .counter_value(counter_value), .top_value(top_value),
        .count_up(count_up), .count_tick(count_tick),
        .channel_compare_value(channel_compare_value), .port_data(port_data),
        .port_dir(port_dir), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    tco_pin_load i_load (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));
    // ------------------------------------------------------------------
    // Closing report, reached from the end and from any timeout
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin num_errors++; print_verdict(); end
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // Program timer1, give one tick, then look at channel A two edges on
    task automatic step(input logic [7:0] c, input logic [7:0] s, input logic up,
                        input logic [15:0] cnt, input logic exp);
        apb(1'b1, tco_pkg::TCO_OFS_CTRL_T1, {24'h0000_00, c});
        apb(1'b1, tco_pkg::TCO_OFS_SECOND_T1, {24'h0000_00, s});
        @(posedge pclk);
        count_up[0] <= up; counter_value[0] <= cnt; count_tick[0] <= 1'b1;
        @(posedge pclk);
        count_tick[0] <= 1'b0;
        @(posedge pclk);
        #1;
        `CHK(pin_out[0][0], exp)
    endtask : step
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, tco_pkg::TCO_OFS_CTRL_T3, 32'h0000_0000);
        `CHK(q, 32'h0000_0000)
        apb(1'b1, tco_pkg::TCO_OFS_CTRL_T3, 32'h0000_00e5);
        apb(1'b0, tco_pkg::TCO_OFS_CTRL_T3, 32'h0000_0000);
        `CHK(q, 32'h0000_00e5)
        apb(1'b0, 8'h14, 32'h0000_0000);
        `CHK(err, 1'b1)
        step(8'h00, 8'h00, 1'b1, 16'h0010, 1'b1);
        step(8'hc0, 8'h00, 1'b1, 16'h0010, 1'b1);
        step(8'h80, 8'h00, 1'b1, 16'h0010, 1'b0);
        step(8'h40, 8'h00, 1'b1, 16'h0010, 1'b1);
        step(8'h40, 8'h00, 1'b1, 16'h0011, 1'b1);
        step(8'h82, 8'h18, 1'b1, 16'h0010, 1'b0);
        step(8'h82, 8'h18, 1'b1, 16'h0000, 1'b1);
        @(posedge pclk);
        top_value[0] <= 16'h0010;
        step(8'h82, 8'h18, 1'b1, 16'h0010, 1'b1);
        step(8'hc2, 8'h10, 1'b1, 16'h0005, 1'b0);
        @(posedge pclk);
        top_value[0] <= 16'h00ff;
        step(8'hc3, 8'h08, 1'b1, 16'h0000, 1'b0);
        step(8'hc3, 8'h08, 1'b1, 16'h0010, 1'b1);
        step(8'h43, 8'h18, 1'b1, 16'h0010, 1'b0);
        step(8'h43, 8'h08, 1'b1, 16'h0010, 1'b1);
        step(8'h80, 8'h10, 1'b1, 16'h0010, 1'b0);
        step(8'h80, 8'h10, 1'b0, 16'h0010, 1'b1);
        step(8'h41, 8'h10, 1'b0, 16'h0010, 1'b0);
        step(8'h40, 8'h10, 1'b0, 16'h0010, 1'b1);
        @(posedge pclk);
        port_dir[0] <= 3'h6;
        @(posedge pclk);
        @(posedge pclk);
        #1;
        `CHK(pin_oe_n[0][0], 1'b1)
        `CHK(pin_level[0][0], 1'b0)
        print_verdict();
    end
endmodule : tb_top

/* sim/tco_pin_load.sv */
// Model of the port pins and their external loads.
// Assumes pin_oe_n low means the block drives the pin.
`timescale 1ns/1ps
module tco_pin_load (
    input wire logic [1:0][2:0] pin_out,
    input wire logic [1:0][2:0] pin_oe_n,
    output logic [1:0][2:0] pin_level
);
    // ------------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------------
    // driven only when enabled
    // A released pin sits on its pull-down, never on the last driven level
    assign pin_level = pin_out & ~pin_oe_n;
endmodule : tco_pin_load

/* verilog/tco_compare_unit.sv */
// Compare-match detection and output-action logic for the three channels of
// one timer. Assumes tick is a one-cycle enable on which the counter holds the
// value just reached.
`timescale 1ns/1ps
module tco_compare_unit (
    tco_chan_if.unit bus
);
    default clocking cb @(posedge bus.clk); endclocking
    default disable iff (!bus.rst_n);

    tco_pkg::tco_mode_class_type cls; // Decoded waveform class
    logic [2:0] match;                // One-cycle compare strobe per channel
    logic [2:0] toggle_ok;            // Toggle action allowed for channel
    logic bottom;                     // Counter at BOTTOM on this tick
    logic [2:0] oc_r;                 // Output levels

    // ------------------------------------------------------------------
    // Decode and strobes
    // ------------------------------------------------------------------
    always_comb begin
        cls = tco_pkg::tco_mode_class(bus.mode);
        bottom = bus.tick && (bus.counter_value == tco_pkg::TCO_CNT_BOTTOM);
        for (int ch = 0; ch < 3; ch++) begin
            match[ch] = bus.tick && (bus.counter_value == bus.compare_value[ch]);
            // toggle on every channel in normal and CTC; in PWM classes only A in modes 15, 9, 11
            if (cls == tco_pkg::TCO_CLS_NORMAL || cls == tco_pkg::TCO_CLS_CTC) begin
                toggle_ok[ch] = 1'b1;
            end else begin
                toggle_ok[ch] = (ch == 0) && ((bus.mode == tco_pkg::TCO_MODE_FAST_A_TOP)
                    || (bus.mode == tco_pkg::TCO_MODE_PFC_A_TOP)
                    || (bus.mode == tco_pkg::TCO_MODE_PC_A_TOP));
            end
            // any nonzero action takes the pin, toggle only where toggle_ok allows
            bus.connect[ch] = (bus.action[ch] != tco_pkg::TCO_ACT_OFF)
                && ((bus.action[ch] != tco_pkg::TCO_ACT_TOGGLE) || toggle_ok[ch]);
        end
    end

    // ------------------------------------------------------------------
    // Output-action state per channel
    // ------------------------------------------------------------------
    always_ff @(posedge bus.clk or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            oc_r <= 3'h0;
        end else begin
            for (int ch = 0; ch < 3; ch++) begin
                case (cls)
                    tco_pkg::TCO_CLS_NORMAL, tco_pkg::TCO_CLS_CTC: begin
                        // toggle, clear or set on match
                        if (match[ch] && bus.action[ch] == tco_pkg::TCO_ACT_TOGGLE) begin
                            oc_r[ch] <= ~oc_r[ch];
                        end else if (match[ch] && bus.action[ch][1]) begin
                            oc_r[ch] <= bus.action[ch][0];
                        end
                    end
                    tco_pkg::TCO_CLS_FAST: begin
                        if (bus.action[ch][1]) begin
                            if (match[ch] && bus.compare_value[ch] != bus.top_value) begin
                                oc_r[ch] <= bus.action[ch][0];
                            end else if (bottom) begin
                                oc_r[ch] <= ~bus.action[ch][0];
                            end
                        end else if (match[ch] && bus.connect[ch]) begin
                            oc_r[ch] <= ~oc_r[ch];
                        end
                    end
                    tco_pkg::TCO_CLS_PC, tco_pkg::TCO_CLS_PFC: begin
                        if (bus.action[ch][1]) begin
                            // extreme compare values hold a level
                            if (bus.tick && bus.compare_value[ch] == tco_pkg::TCO_CNT_BOTTOM) begin
                                oc_r[ch] <= bus.action[ch][0];
                            end else if (bus.tick && bus.compare_value[ch] == bus.top_value) begin
                                oc_r[ch] <= ~bus.action[ch][0];
                            end else if (match[ch]) begin
                                oc_r[ch] <= bus.count_up ? bus.action[ch][0]
                                                         : ~bus.action[ch][0];
                            end
                        end else if (match[ch] && bus.connect[ch]) begin
                            oc_r[ch] <= ~oc_r[ch];
                        end
                    end
                    default: begin
                        // Reserved mode holds the level
                        oc_r[ch] <= oc_r[ch];
                    end
                endcase
            end
        end
    end

    assign bus.oc = oc_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_nonpwm_set_on_match: assert property (
        (cls == tco_pkg::TCO_CLS_NORMAL) && match[1] && bus.action[1] == tco_pkg::TCO_ACT_SET
        |=> oc_r[1]) else $error("Set on match not applied");
    a_fast_bottom_set: assert property (
        (cls == tco_pkg::TCO_CLS_FAST) && bottom && !match[0]
        && bus.action[0] == tco_pkg::TCO_ACT_CLEAR |=> oc_r[0])
        else $error("Fast non-inverting not set at bottom");
    a_fast_top_ignored: assert property (
        (cls == tco_pkg::TCO_CLS_FAST) && bus.action[2][1] && !bottom
        && bus.compare_value[2] == bus.top_value |=> $stable(oc_r[2]))
        else $error("Fast match at top was not ignored");
    a_dual_up_clear: assert property (
        (cls == tco_pkg::TCO_CLS_PFC) && match[0] && bus.count_up
        && bus.action[0] == tco_pkg::TCO_ACT_CLEAR
        && bus.compare_value[0] != tco_pkg::TCO_CNT_BOTTOM
        && bus.compare_value[0] != bus.top_value |=> !oc_r[0])
        else $error("Dual slope up match did not clear");

endmodule : tco_compare_unit

/* verilog/tco_output_control.sv */
// Compare-output control for two 16-bit timers with three channels each:
// APB registers, waveform-mode assembly, channel units and pin multiplexing.
// Assumes timer cores and port logic on pclk feed counter state and port data.
`timescale 1ns/1ps

// Notes on behaviour
// - Action fields 7:6,5:4,3:2, mode bits 1:0
// - Nonzero action hands pin to compare output, toggle only where allowed
// - Action 00 leaves port in control
// - Non-PWM: toggle, clear or set on match
// - Fast toggle only channel A, mode 15
// - Fast 10 clears on match, sets at BOTTOM
// - Fast 11 sets on match, clears at BOTTOM
// - Fast clear/set, compare at TOP: match ignored
// - Fast table applies in every fast mode
// - Dual slope: direction picks clear or set
// - Dual toggle only channel A, modes 9/11
// - Four-bit mode decodes into waveform classes
// - Upper mode bits from second register 4:3
// - Dual slope clear/set: extreme compare values hold level
module tco_output_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0][15:0] counter_value,
    input wire logic [1:0][15:0] top_value,
    input wire logic [1:0] count_up,
    input wire logic [1:0] count_tick,
    input wire logic [1:0][2:0][15:0] channel_compare_value,
    input wire logic [1:0][2:0] port_data,
    input wire logic [1:0][2:0] port_dir,
    output logic [1:0][2:0] pin_out,
    output logic [1:0][2:0] pin_oe_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------------
    // Storage and internal nets
    // ------------------------------------------------------------------
    logic [1:0][7:0] ctrl_r;          // Output and mode control per timer
    logic [1:0][1:0] second_r;        // waveform_mode_high per timer
    logic [31:0] prdata_r;            // Registered read data
    logic pready_r;                   // One wait state then ready
    logic pslverr_r;                  // Error on unmapped address
    logic [1:0][2:0] pin_out_r;       // Pin level
    logic [1:0][2:0] pin_oe_n_r;      // Pin enable, low drives
    logic [1:0][2:0] oc_w;            // Output levels from units
    logic [1:0][2:0] conn_w;          // Connections from units
    logic access_done;                // Transfer completes this edge
    logic addr_hit;                   // Address maps to a register

    // Transfer completes on the edge where ready is sampled high
    assign access_done = psel && penable && pready_r;

    // Map check used by the error logic; reads decode paddr themselves
    function automatic logic tco_mapped(input logic [7:0] a);
        tco_mapped = (a == tco_pkg::TCO_OFS_CTRL_T1) || (a == tco_pkg::TCO_OFS_CTRL_T3)
            || (a == tco_pkg::TCO_OFS_SECOND_T1) || (a == tco_pkg::TCO_OFS_SECOND_T3)
            || (a == tco_pkg::TCO_OFS_STATUS);
    endfunction : tco_mapped

    assign addr_hit = tco_mapped(paddr);

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // Writes land only on the completing edge, so a stalled master never
    // writes twice.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= {2{tco_pkg::TCO_CTRL_RST}};
            second_r <= {2{tco_pkg::TCO_SECOND_RST}};
        end else if (access_done && pwrite) begin
            if (paddr == tco_pkg::TCO_OFS_CTRL_T1) begin
                ctrl_r[0] <= pwdata[7:0];
            end else if (paddr == tco_pkg::TCO_OFS_CTRL_T3) begin
                ctrl_r[1] <= pwdata[7:0];
            end else if (paddr == tco_pkg::TCO_OFS_SECOND_T1) begin
                // only the mode-high bits are kept
                second_r[0] <= pwdata[tco_pkg::TCO_MODE_HIGH_POS +: 2];
            end else if (paddr == tco_pkg::TCO_OFS_SECOND_T3) begin
                second_r[1] <= pwdata[tco_pkg::TCO_MODE_HIGH_POS +: 2];
            end
        end
    end

    // ------------------------------------------------------------------
    // APB response
    // ------------------------------------------------------------------
    // One wait state keeps read data coming straight from a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (psel && penable && !pready_r) begin
            pready_r <= 1'b1;
            pslverr_r <= !addr_hit;
            // Read decode; unmapped reads give zero
            if (pwrite) begin
                prdata_r <= 32'h0000_0000;
            end else if (paddr == tco_pkg::TCO_OFS_CTRL_T1) begin
                prdata_r <= {24'h00_0000, ctrl_r[0]};
            end else if (paddr == tco_pkg::TCO_OFS_CTRL_T3) begin
                prdata_r <= {24'h00_0000, ctrl_r[1]};
            end else if (paddr == tco_pkg::TCO_OFS_SECOND_T1) begin
                prdata_r <= 32'({second_r[0], 3'h0});
            end else if (paddr == tco_pkg::TCO_OFS_SECOND_T3) begin
                prdata_r <= 32'({second_r[1], 3'h0});
            end else if (paddr == tco_pkg::TCO_OFS_STATUS) begin
                // Status shows the block's live state
                prdata_r <= 32'({conn_w, 2'h0, oc_w});
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // ------------------------------------------------------------------
    // Per-timer channel units
    // ------------------------------------------------------------------
    for (genvar t = 0; t < 2; t++) begin : g_tmr
        tco_chan_if cif (
            .clk(pclk),
            .rst_n(presetn)
        );
        // field positions of the three channels
        assign cif.action[0] = ctrl_r[t][tco_pkg::TCO_CHAN_A_POS +: 2];
        assign cif.action[1] = ctrl_r[t][tco_pkg::TCO_CHAN_B_POS +: 2];
        assign cif.action[2] = ctrl_r[t][tco_pkg::TCO_CHAN_C_POS +: 2];
        // high bits joined to low bits
        assign cif.mode = {second_r[t], ctrl_r[t][tco_pkg::TCO_MODE_LOW_POS +: 2]};
        assign cif.counter_value = counter_value[t];
        assign cif.top_value = top_value[t];
        assign cif.compare_value = channel_compare_value[t];
        assign cif.count_up = count_up[t];
        assign cif.tick = count_tick[t];
        assign oc_w[t] = cif.oc;
        assign conn_w[t] = cif.connect;

        // Three-channel compare and action logic
        tco_compare_unit u_unit (
            .bus(cif.unit)
        );
    end

    // ------------------------------------------------------------------
    // Pin multiplexing
    // ------------------------------------------------------------------
    // The compare output only replaces the level; the driver still needs the
    // direction bit, so a connected channel with direction clear stays quiet.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_r <= 6'h00;
            pin_oe_n_r <= 6'h3F;
        end else begin
            for (int t = 0; t < 2; t++) begin
                for (int ch = 0; ch < 3; ch++) begin
                    pin_out_r[t][ch] <= conn_w[t][ch] ? oc_w[t][ch] : port_data[t][ch];
                    pin_oe_n_r[t][ch] <= !port_dir[t][ch];
                end
            end
        end
    end

    assign pin_out = pin_out_r;
    assign pin_oe_n = pin_oe_n_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_ctrl_write_lands: assert property (
        access_done && pwrite && paddr == tco_pkg::TCO_OFS_CTRL_T3
        |=> ctrl_r[1] == $past(pwdata[7:0]))
        else $error("Control write did not land");

    // The edge that releases reset still loads the reset levels, so the
    // check starts one edge later.
    a_pin_dir_gate: assert property (
        $past(presetn) |-> pin_oe_n == ~$past(port_dir))
        else $error("Pin enable does not follow direction");

    a_port_when_off: assert property (
        presetn && ctrl_r[0][tco_pkg::TCO_CHAN_A_POS +: 2] == tco_pkg::TCO_ACT_OFF
        |=> pin_out[0][0] == $past(port_data[0][0]))
        else $error("Disconnected pin not under port control");

    // Upper action bit set connects the channel in every mode
    a_connect_drives: assert property (
        ctrl_r[1][tco_pkg::TCO_CHAN_B_POS + 1]
        |=> pin_out[1][1] == $past(oc_w[1][1]))
        else $error("Connected pin does not show compare output");

    a_mode_assembled: assert property (
        access_done && pwrite && paddr == tco_pkg::TCO_OFS_SECOND_T1
        |=> ##1 g_tmr[0].cif.mode[3:2] == $past(pwdata[4:3], 2))
        else $error("Mode high bits not taken from second register");

    a_apb_ready_pulse: assert property (
        psel && penable && !pready_r |=> pready_r ##1 !pready_r)
        else $error("Ready not a single pulse after one wait");

    a_unmapped_error: assert property (
        psel && penable && !pready_r && !addr_hit |=> pslverr_r && prdata_r == 32'h0000_0000)
        else $error("Unmapped access not refused");

endmodule : tco_output_control
